// ---- uja_pkg.sv ----
`default_nettype none

package uja_pkg;

	// ----------------------------------------
	// Instruction register
	// ----------------------------------------
	localparam int UJA_IR_W = 8;
	localparam logic [7:0] UJA_IR_RESET = 8'hff;
	localparam logic [7:0] UJA_IR_CAPTURE = 8'h01;
	localparam logic [7:0] UJA_USER_LO = 8'h10;
	localparam logic [7:0] UJA_USER_HI = 8'h7f;

	// ----------------------------------------
	// Pin synchroniser lanes
	// ----------------------------------------
	localparam int UJA_SYNC_W = 5;
	localparam int UJA_BIT_TCK = 0;
	localparam int UJA_BIT_TMS = 1;
	localparam int UJA_BIT_TDI = 2;
	localparam int UJA_BIT_TRST = 3;
	localparam int UJA_BIT_UDO = 4;
	localparam logic [4:0] UJA_SYNC_RESET = 5'h0e;

	// ----------------------------------------
	// Event buffer
	// ----------------------------------------
	localparam int UJA_FIFO_DEPTH = 4;

	typedef enum logic [3:0] {
		ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR,
		ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
	} uja_tap_state_e;

	typedef struct packed {
		logic user;
		logic [7:0] code;
	} uja_ir_evt_s;

endpackage : uja_pkg

`default_nettype wire

// ---- uja_user_scan_access.sv ----
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Current instruction register contents appear on an eight-bit output bus.
// - Codes sixteen to one hundred twenty-seven are user instructions.
// - Active-low user reset is low while the controller sits in Test-Logic-Reset.
// - Power-on reset forces Test-Logic-Reset, so the user reset is asserted.
// - User serial input is an unregistered copy of the serial data at the port.
// - In a user instruction, user serial output drives the port serial output during Shift-DR.
// - Shift strobe high only in Shift-DR.
// - Capture strobe high only in Capture-DR.
// - Update strobe high only in Update-DR.
// - User shift clock is the test clock passed straight through.
// - Active-low test reset returns the controller to Test-Logic-Reset.
// - Override enable swaps serial input and test reset; tie low if unused.
// - With override on, serial data comes from the override serial input.
// - With override on, test reset comes from the override reset input.

// ----------------------------------------
// Event buffer
// ----------------------------------------
module uja_evt_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 4
) (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] count_reg;
	logic push;
	logic pop;

	assign o_in_ready = (count_reg != (AW+1)'(DEPTH));
	assign o_out_valid = (count_reg != '0);
	assign o_out_data = mem_reg[rd_ptr_reg];
	assign push = i_in_valid && o_in_ready;
	assign pop = o_out_valid && i_out_ready;

	always_ff @(posedge i_clk)
	begin
		if (push)
			mem_reg[wr_ptr_reg] <= i_in_data;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
			if (push && !pop)
				count_reg <= count_reg + 1'b1;
			else if (pop && !push)
				count_reg <= count_reg - 1'b1;
		end
	end

	chk_fifo_no_overrun: assert property (@(posedge i_clk) disable iff (i_srst)
		i_in_valid |-> o_in_ready)
		else $error("event offered while buffer full");

endmodule : uja_evt_fifo

// ----------------------------------------
// Test access port with user access
// ----------------------------------------
module uja_user_scan_access (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_tck,
	input wire logic i_tms,
	input wire logic i_tdi,
	input wire logic i_test_reset_n,
	output logic o_tdo,
	output logic o_tdo_oe,
	input wire logic i_override_enable,
	input wire logic i_override_serial_in,
	input wire logic i_override_test_reset_n,
	output logic [7:0] o_user_instruction_bus,
	output logic o_user_tap_reset_n,
	output logic o_user_serial_in,
	input wire logic i_user_serial_out,
	output logic o_dr_shift_strobe,
	output logic o_dr_capture_strobe,
	output logic o_dr_update_strobe,
	output logic o_user_shift_clock,
	output logic o_evt_valid,
	input wire logic i_evt_ready,
	output uja_pkg::uja_ir_evt_s o_evt
);
	import uja_pkg::*;

	function automatic logic is_user(input logic [7:0] code);
		is_user = (code >= UJA_USER_LO) && (code <= UJA_USER_HI);
	endfunction : is_user

	// ----------------------------------------
	// Pass-through and override muxes
	// ----------------------------------------
	logic tap_tdi;
	logic tap_trst_n;

	assign tap_tdi = i_override_enable ? i_override_serial_in : i_tdi;
	// Override enable selects both replacements together
	assign tap_trst_n = i_override_enable ? i_override_test_reset_n : i_test_reset_n;
	assign o_user_serial_in = tap_tdi;
	assign o_user_shift_clock = i_tck;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [UJA_SYNC_W-1:0] pins;
	logic [UJA_SYNC_W-1:0] s1_reg;
	logic [UJA_SYNC_W-1:0] s2_reg;
	logic [UJA_SYNC_W-1:0] s3_reg;
	logic [UJA_SYNC_W-1:0] stable_reg;

	assign pins = {i_user_serial_out, tap_trst_n, tap_tdi, i_tms, i_tck};

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			s1_reg <= UJA_SYNC_RESET;
			s2_reg <= UJA_SYNC_RESET;
			s3_reg <= UJA_SYNC_RESET;
			stable_reg <= UJA_SYNC_RESET;
		end
		else
		begin
			s1_reg <= pins;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			for (int i = 0; i < UJA_SYNC_W; i++)
				if (s2_reg[i] == s3_reg[i])
					stable_reg[i] <= s3_reg[i];
		end
	end

	logic tck_rise;
	logic tck_fall;

	assign tck_rise = (s2_reg[UJA_BIT_TCK] == s3_reg[UJA_BIT_TCK]) &&
		s3_reg[UJA_BIT_TCK] && !stable_reg[UJA_BIT_TCK];
	assign tck_fall = (s2_reg[UJA_BIT_TCK] == s3_reg[UJA_BIT_TCK]) &&
		!s3_reg[UJA_BIT_TCK] && stable_reg[UJA_BIT_TCK];

	// ----------------------------------------
	// Held rising edge
	// ----------------------------------------
	uja_tap_state_e state_reg;
	uja_tap_state_e state_next;
	logic pend_reg;
	logic tms_reg;
	logic tdi_reg;
	logic fifo_ready;
	logic tap_adv;
	logic evt_push;

	// Entry to Update-IR waits for room in the event buffer
	assign tap_adv = pend_reg && stable_reg[UJA_BIT_TRST] &&
		!(state_next == ST_UPD_IR && !fifo_ready);
	assign evt_push = tap_adv && (state_next == ST_UPD_IR);

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			pend_reg <= 1'b0;
		else if (!stable_reg[UJA_BIT_TRST])
			pend_reg <= 1'b0;
		else if (tck_rise)
			pend_reg <= 1'b1;
		else if (tap_adv)
			pend_reg <= 1'b0;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			tms_reg <= 1'b1;
			tdi_reg <= 1'b1;
		end
		else if (tck_rise)
		begin
			tms_reg <= s3_reg[UJA_BIT_TMS];
			tdi_reg <= s3_reg[UJA_BIT_TDI];
		end
	end

	// ----------------------------------------
	// Controller state machine
	// ----------------------------------------
	always_comb
	begin
		unique case (state_reg)
			ST_TLR: state_next = tms_reg ? ST_TLR : ST_RTI;
			ST_RTI: state_next = tms_reg ? ST_SEL_DR : ST_RTI;
			ST_SEL_DR: state_next = tms_reg ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: state_next = tms_reg ? ST_EX1_DR : ST_SH_DR;
			ST_SH_DR: state_next = tms_reg ? ST_EX1_DR : ST_SH_DR;
			ST_EX1_DR: state_next = tms_reg ? ST_UPD_DR : ST_PAU_DR;
			ST_PAU_DR: state_next = tms_reg ? ST_EX2_DR : ST_PAU_DR;
			ST_EX2_DR: state_next = tms_reg ? ST_UPD_DR : ST_SH_DR;
			ST_UPD_DR: state_next = tms_reg ? ST_SEL_DR : ST_RTI;
			ST_SEL_IR: state_next = tms_reg ? ST_TLR : ST_CAP_IR;
			ST_CAP_IR: state_next = tms_reg ? ST_EX1_IR : ST_SH_IR;
			ST_SH_IR: state_next = tms_reg ? ST_EX1_IR : ST_SH_IR;
			ST_EX1_IR: state_next = tms_reg ? ST_UPD_IR : ST_PAU_IR;
			ST_PAU_IR: state_next = tms_reg ? ST_EX2_IR : ST_PAU_IR;
			ST_EX2_IR: state_next = tms_reg ? ST_UPD_IR : ST_SH_IR;
			ST_UPD_IR: state_next = tms_reg ? ST_SEL_DR : ST_RTI;
		endcase
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			state_reg <= ST_TLR;
		else if (!stable_reg[UJA_BIT_TRST])
			state_reg <= ST_TLR;
		else if (tap_adv)
			state_reg <= state_next;
	end

	// ----------------------------------------
	// Instruction and bypass registers
	// ----------------------------------------
	logic [7:0] ir_shift_reg;
	logic [7:0] ir_reg;
	logic bypass_reg;

	always_ff @(posedge i_clk)
	begin
		if (i_srst || state_reg == ST_TLR)
		begin
			ir_shift_reg <= UJA_IR_CAPTURE;
			ir_reg <= UJA_IR_RESET;
		end
		else if (tap_adv)
		begin
			if (state_reg == ST_CAP_IR)
				ir_shift_reg <= UJA_IR_CAPTURE;
			else if (state_reg == ST_SH_IR)
				ir_shift_reg <= {tdi_reg, ir_shift_reg[7:1]};
			if (state_next == ST_UPD_IR)
				ir_reg <= ir_shift_reg;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			bypass_reg <= 1'b0;
		else if (tap_adv && state_reg == ST_CAP_DR)
			bypass_reg <= 1'b0;
		else if (tap_adv && state_reg == ST_SH_DR)
			bypass_reg <= tdi_reg;
	end

	assign o_user_instruction_bus = ir_reg;

	// ----------------------------------------
	// User strobes and reset
	// ----------------------------------------
	assign o_user_tap_reset_n = (state_reg != ST_TLR);
	assign o_dr_shift_strobe = (state_reg == ST_SH_DR);
	assign o_dr_capture_strobe = (state_reg == ST_CAP_DR);
	assign o_dr_update_strobe = (state_reg == ST_UPD_DR);

	// ----------------------------------------
	// Serial output on falling edge
	// ----------------------------------------
	logic tdo_reg;
	logic tdo_oe_reg;

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			tdo_reg <= 1'b0;
			tdo_oe_reg <= 1'b0;
		end
		else if (tck_fall)
		begin
			tdo_oe_reg <= (state_reg == ST_SH_IR) || (state_reg == ST_SH_DR);
			if (state_reg == ST_SH_IR)
				tdo_reg <= ir_shift_reg[0];
			else if (state_reg == ST_SH_DR && is_user(ir_reg))
				tdo_reg <= stable_reg[UJA_BIT_UDO];
			else if (state_reg == ST_SH_DR)
				tdo_reg <= bypass_reg;
		end
	end

	assign o_tdo = tdo_reg;
	assign o_tdo_oe = tdo_oe_reg;

	// ----------------------------------------
	// Instruction update events
	// ----------------------------------------
	uja_ir_evt_s evt_in;

	assign evt_in.code = ir_shift_reg;
	assign evt_in.user = is_user(ir_shift_reg);

	uja_evt_fifo #(
		.WIDTH($bits(uja_ir_evt_s)),
		.DEPTH(UJA_FIFO_DEPTH)
	) u_evt_fifo (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.i_in_valid(evt_push),
		.o_in_ready(fifo_ready),
		.i_in_data(evt_in),
		.o_out_valid(o_evt_valid),
		.i_out_ready(i_evt_ready),
		.o_out_data(o_evt)
	);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_por_reset_low: assert property (@(posedge i_clk)
		i_srst |=> !o_user_tap_reset_n)
		else $error("user reset not asserted after power-on reset");

	chk_trst_forces_tlr: assert property (@(posedge i_clk) disable iff (i_srst)
		!stable_reg[UJA_BIT_TRST] |=> !o_user_tap_reset_n && !o_dr_shift_strobe)
		else $error("test reset did not return controller to reset state");

	chk_ovr_trst_path: assert property (@(posedge i_clk) disable iff (i_srst)
		(i_override_enable && !i_override_test_reset_n)[*5] |=> !o_user_tap_reset_n)
		else $error("override test reset not honoured");

	chk_ovr_tdi_path: assert property (@(posedge i_clk) disable iff (i_srst)
		i_override_enable |-> ##3 s3_reg[UJA_BIT_TDI] == $past(i_override_serial_in, 3))
		else $error("override serial input not routed");

	chk_tlr_exit: assert property (@(posedge i_clk) disable iff (i_srst)
		tap_adv && state_reg == ST_TLR && !tms_reg && stable_reg[UJA_BIT_TRST]
		|=> state_reg == ST_RTI)
		else $error("controller did not leave reset on low mode select");

	chk_cap_then_shift: assert property (@(posedge i_clk) disable iff (i_srst)
		o_dr_capture_strobe && tap_adv && !tms_reg && stable_reg[UJA_BIT_TRST]
		|=> o_dr_shift_strobe && !o_dr_capture_strobe)
		else $error("capture strobe not followed by shift strobe");

	chk_update_entry: assert property (@(posedge i_clk) disable iff (i_srst)
		$rose(o_dr_update_strobe) |->
		$past(state_reg) == ST_EX1_DR || $past(state_reg) == ST_EX2_DR)
		else $error("update strobe entered from wrong state");

	chk_ir_update: assert property (@(posedge i_clk) disable iff (i_srst)
		evt_push && stable_reg[UJA_BIT_TRST]
		|=> o_user_instruction_bus == $past(ir_shift_reg))
		else $error("instruction bus not updated");

	chk_user_tdo: assert property (@(posedge i_clk) disable iff (i_srst)
		tck_fall && state_reg == ST_SH_DR && is_user(ir_reg)
		|=> o_tdo == $past(stable_reg[UJA_BIT_UDO]) && o_tdo_oe)
		else $error("user serial output not routed to port");

endmodule : uja_user_scan_access

`default_nettype wire

// ---- uja_jtag_ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----
// External test controller
// ----
module uja_jtag_ctrl_model (
	input wire logic i_clk,
	input wire logic i_tdo,
	output var logic o_tck,
	output var logic o_tms,
	output var logic o_tdi
);
	initial
	begin
		o_tck = 1'b0;
		o_tms = 1'b1;
		o_tdi = 1'b1;
	end
	// Sample output, rise, fall, then release to pull-up level
	task automatic bit_cycle(input logic tms, input logic tdi, output logic tdo);
		@(negedge i_clk);
		tdo = i_tdo;
		o_tms = tms;
		o_tdi = tdi;
		@(negedge i_clk);
		o_tck = 1'b1;
		repeat (5) @(negedge i_clk);
		o_tck = 1'b0;
		repeat (5) @(negedge i_clk);
		o_tms = 1'b1;
		o_tdi = 1'b1;
	endtask : bit_cycle
endmodule : uja_jtag_ctrl_model
`default_nettype wire

// ---- user_jtag_access_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----
// Bench with reference model
// ----
module user_jtag_access_tb;
	import uja_pkg::*;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic trst = 1'b1;
	logic ovr = 1'b0;
	logic osi = 1'b0;
	logic orst = 1'b1;
	logic uso = 1'b0;
	logic rdy = 1'b1;
	logic tck, tms, tdi, tdo, oe, usi, ush, cap, upd, urst, usck, evv;
	logic [7:0] ibus;
	uja_ir_evt_s evt;
	logic [15:0] rnd = 16'h9a3f;
	logic [7:0] ir = 8'hff;
	logic [7:0] sr = 8'h00;
	logic byp = 1'b0;
	logic shifting = 1'b0;
	logic exp_tdo = 1'b0;
	logic [8:0] evq[$];
	int st = 0;
	int err_count = 0;
	int tests_run = 0;
	int cyc = 0;
	int nx0[16] = '{1, 1, 3, 4, 4, 6, 6, 4, 1, 10, 11, 11, 13, 13, 11, 1};
	int nx1[16] = '{0, 2, 9, 5, 5, 8, 7, 8, 2, 0, 12, 12, 15, 14, 15, 2};
	initial
	begin
		forever #50 clk = ~clk;
	end
	uja_user_scan_access u_uja_user_scan_access (.i_clk(clk), .i_srst(srst), .i_tck(tck),
		.i_tms(tms), .i_tdi(tdi), .i_test_reset_n(trst), .o_tdo(tdo), .o_tdo_oe(oe),
		.i_override_enable(ovr), .i_override_serial_in(osi), .i_override_test_reset_n(orst),
		.o_user_instruction_bus(ibus), .o_user_tap_reset_n(urst), .o_user_serial_in(usi),
		.i_user_serial_out(uso), .o_dr_shift_strobe(ush), .o_dr_capture_strobe(cap),
		.o_dr_update_strobe(upd), .o_user_shift_clock(usck), .o_evt_valid(evv),
		.i_evt_ready(rdy), .o_evt(evt));
	// Released tdo line is seen inverted by the controller
	uja_jtag_ctrl_model u_uja_jtag_ctrl_model (.i_clk(clk), .i_tdo(oe ? tdo : ~tdo),
		.o_tck(tck), .o_tms(tms), .o_tdi(tdi));
	// User side copy of the shift clock, checked against tck
	logic gck;
	assign gck = usck;
	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : lfsr
	task automatic check(input logic [8:0] got, input logic [8:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : wrap_up
	task automatic check_outs();
		check({1'b0, ibus}, {1'b0, ir});
		check({8'h00, urst}, {8'h00, st != 0});
		check({5'h00, ush, cap, upd, oe}, {5'h00, st == 4, st == 3, st == 8, shifting});
	endtask : check_outs
	task automatic step(input logic m, input logic d);
		logic seen;
		logic old_sh;
		logic old_exp;
		old_sh = shifting;
		old_exp = exp_tdo;
		@(negedge clk);
		rnd = lfsr(rnd);
		uso = rnd[0];
		osi = d;
		if (st == 10)
			sr = 8'h01;
		else if (st == 11)
			sr = {d, sr[7:1]};
		if (st == 3)
			byp = 1'b0;
		else if (st == 4)
			byp = d;
		st = m ? nx1[st] : nx0[st];
		if (st == 15)
		begin
			ir = sr;
			evq.push_back({ir >= UJA_USER_LO && ir <= UJA_USER_HI, ir});
		end
		shifting = st == 4 || st == 11;
		exp_tdo = st == 11 ? sr[0] : (ir >= UJA_USER_LO && ir <= UJA_USER_HI ? uso : byp);
		u_uja_jtag_ctrl_model.bit_cycle(m, ovr ? ~d : d, seen);
		if (old_sh)
			check({8'h00, seen}, {8'h00, old_exp});
		check_outs();
	endtask : step
	task automatic load_ir(input logic [7:0] c);
		step(1'b0, 1'b0);
		step(1'b1, 1'b0);
		step(1'b1, 1'b0);
		step(1'b0, 1'b0);
		step(1'b0, 1'b0);
		for (int i = 0; i < 8; i++)
			step(i == 7, c[i]);
		if (c[0])
		begin
			step(1'b0, 1'b0);
			step(1'b1, 1'b0);
		end
		step(1'b1, 1'b0);
		step(1'b0, 1'b0);
	endtask : load_ir
	task automatic scan_dr(input int n);
		step(1'b0, 1'b0);
		step(1'b1, 1'b0);
		step(1'b0, 1'b0);
		step(1'b0, 1'b0);
		for (int i = 0; i < n; i++)
		begin
			rnd = lfsr(rnd);
			step(i == n - 1, rnd[3]);
		end
		step(1'b0, 1'b0);
		step(1'b1, 1'b0);
		step(1'b1, 1'b0);
		step(1'b0, 1'b0);
	endtask : scan_dr
	// Pull one reset line low; hit says whether it should take effect
	task automatic pulse(input logic pin, input logic hit);
		@(negedge clk);
		if (pin)
			trst = 1'b0;
		else
			orst = 1'b0;
		repeat (8) @(negedge clk);
		trst = 1'b1;
		orst = 1'b1;
		repeat (6) @(negedge clk);
		if (hit)
		begin
			st = 0;
			ir = 8'hff;
		end
		check_outs();
	endtask : pulse
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			err_count++;
			wrap_up();
		end
		else
		begin
			if (!srst)
			begin
				check({8'h00, gck}, {8'h00, tck});
				check({8'h00, usi}, {8'h00, ovr ? osi : tdi});
			end
			if (evv === 1'b1 && rdy)
			begin
				check(evt, evq.size() > 0 ? evq[0] : 9'h1ff);
				if (evq.size() > 0)
					void'(evq.pop_front());
			end
		end
	end
	initial
	begin
		repeat (10) @(negedge clk);
		srst = 1'b0;
		check_outs();
		$display("reset test done");
		rdy = 1'b0;
		load_ir(8'h10);
		load_ir(8'h7f);
		load_ir(8'h0f);
		load_ir(8'h80);
		check({8'h00, evv}, 9'h001);
		rdy = 1'b1;
		repeat (8) @(negedge clk);
		check(9'(evq.size()), 9'h000);
		$display("buffer test done");
		rnd = lfsr(rnd);
		load_ir(8'h10 | {1'b0, rnd[6:0]});
		scan_dr(12);
		load_ir(8'hff);
		scan_dr(6);
		$display("scan test done");
		ovr = 1'b1;
		load_ir(8'h2a);
		scan_dr(5);
		pulse(1'b1, 1'b0);
		pulse(1'b0, 1'b1);
		ovr = 1'b0;
		load_ir(8'h33);
		pulse(1'b0, 1'b0);
		pulse(1'b1, 1'b1);
		$display("override and test reset done");
		load_ir(8'h44);
		srst = 1'b1;
		repeat (2) @(negedge clk);
		srst = 1'b0;
		st = 0;
		ir = 8'hff;
		check_outs();
		check(9'(evq.size()), 9'h000);
		$display("second reset test done");
		wrap_up();
	end
endmodule : user_jtag_access_tb
`default_nettype wire
